// ---- verilog/ago_pkg.sv ----
package ago_pkg;

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OSCILLATOR_CYCLE_MONITOR_OFFS = 8'h10;
   localparam logic [7:0] GAIN_CORR_OFFS   = 8'h11;
   localparam logic [7:0] OFFS_CORR_OFFS   = 8'h12;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int GAIN_SEL_LSB  = 14;
   localparam int GAIN_WORD_LSB = 0;
   localparam int OFFS_SEL_LSB  = 14;
   localparam int OFFS1_LSB     = 7;
   localparam int OFFS2_LSB     = 0;

   // -----------------------------------------------------------------
   // Values after reset
   // -----------------------------------------------------------------
   localparam logic [15:0] OSC_TALLY_RST = 16'h0000;
   localparam logic [1:0]  GAIN_SEL_RST  = 2'h0;
   localparam logic [10:0] GAIN_WORD_RST = 11'h000;
   localparam logic [1:0]  OFFS_SEL_RST  = 2'h0;
   localparam logic [6:0]  OFFS_WORD_RST = 7'h00;
   localparam logic [15:0] RDATA_RST     = 16'h0000;

   // -----------------------------------------------------------------
   // Codes and scaling
   // -----------------------------------------------------------------
   // Axis codes shared by gain selector and offset steering
   localparam logic [1:0] AXIS_NONE = 2'h0;
   localparam logic [1:0] AXIS_X    = 2'h1;
   localparam logic [1:0] AXIS_Y    = 2'h2;
   localparam logic [1:0] AXIS_Z    = 2'h3;
   // Angle axis pair codes
   localparam logic [1:0] PAIR_NONE = 2'h0;
   localparam logic [1:0] PAIR_01   = 2'h1;
   localparam logic [1:0] PAIR_10   = 2'h2;
   localparam logic [1:0] PAIR_11   = 2'h3;
   // Counter control codes
   localparam logic [1:0] CNT_CLEAR = 2'h0;
   localparam logic [1:0] CNT_FAST  = 2'h1;
   localparam logic [1:0] CNT_SLOW  = 2'h2;
   localparam logic [1:0] CNT_STOP  = 2'h3;
   // Gain is word / 2**GAIN_FRAC_BITS, i.e. word / 1024
   localparam int GAIN_FRAC_BITS = 10;
   // Offset is the low 7 bits of an 11-bit scale; samples are 16 bits
   localparam int OFFS_SHIFT     = 16 - 11;

endpackage

// ---- verilog/ago_sync.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous levels
module ago_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule

// ---- verilog/ago_osc_counter.sv ----
`timescale 1ns/1ps
// Oscillator cycle tally, counting edges of synchronised oscillators
module ago_osc_counter (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        fast_sync,
   input  wire logic        slow_sync,
   input  wire logic [1:0]  cycle_counter_control,
   output logic      [15:0] osc_cycle_tally
);

   logic fast_d_r;
   logic slow_d_r;
   logic fast_rise;
   logic slow_rise;

   // Edge history taken from the synchronised level only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fast_d_r <= 1'b0;
         slow_d_r <= 1'b0;
      end else begin
         fast_d_r <= fast_sync;
         slow_d_r <= slow_sync;
      end
   end

   assign fast_rise = fast_sync & ~fast_d_r;
   assign slow_rise = slow_sync & ~slow_d_r;

   // Oscillators must run below half of clk or cycles are missed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_cycle_tally <= ago_pkg::OSC_TALLY_RST;
      end else begin
         unique case (cycle_counter_control)
            ago_pkg::CNT_CLEAR: begin
               osc_cycle_tally <= ago_pkg::OSC_TALLY_RST; // [R3]
            end
            ago_pkg::CNT_FAST: begin
               if (fast_rise) begin
                  osc_cycle_tally <= osc_cycle_tally + 16'h0001; // [R2]
               end
            end
            ago_pkg::CNT_SLOW: begin
               if (slow_rise) begin
                  osc_cycle_tally <= osc_cycle_tally + 16'h0001; // [R2]
               end
            end
            ago_pkg::CNT_STOP: osc_cycle_tally <= osc_cycle_tally; // [R3]
         endcase
      end
   end

endmodule

// ---- verilog/ago_regs.sv ----
`timescale 1ns/1ps
// Operation
// [R1] Read-only oscillator cycle tally register
// [R2] Tally is 16 bits and wraps around
// [R3] Control: 0 clear, 1 fast, 2 slow, 3 stop
// [R4] Gain selector: none, X, Y or Z
// [R5] Selected axis multiplied by gain word/1024
// [R6] Offset selector 00: no offset correction
// [R7] Selector 01: first word to X or Y
// [R8] Selector 10: second word to Y or Z
// [R9] Selector 11: both words; pair 00 none
// [R10] Offset words are 7-bit two's complement
// [R11] Offset words are low bits of 11-bit scale
// [R12] Gain reserved bits read zero, ignore writes
module ago_regs (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   output logic             reg_rvalid,
   input  wire logic [1:0]  cycle_counter_control,
   input  wire logic        fast_internal_oscillator,
   input  wire logic        slow_internal_oscillator,
   input  wire logic [1:0]  angle_pair_code,
   input  wire logic        axis_valid,
   input  wire logic [15:0] axis_x,
   input  wire logic [15:0] axis_y,
   input  wire logic [15:0] axis_z,
   output logic             corr_valid,
   output logic      [15:0] corr_x,
   output logic      [15:0] corr_y,
   output logic      [15:0] corr_z
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [1:0]  osc_sync;
   logic [15:0] osc_cycle_tally;
   logic [1:0]  gain_sel_r;
   logic [10:0] gain_word_r;
   logic [1:0]  offs_sel_r;
   logic [6:0]  first_offset_word_r;
   logic [6:0]  second_offset_word_r;
   logic [15:0] gain_reg_view;
   logic [15:0] offs_reg_view;
   logic [15:0] rdata_nxt;
   logic [1:0]  off1_axis;
   logic [1:0]  off2_axis;
   logic [15:0] axis_in [3];

   // ----------------------------------------------------------------
   // Oscillator monitor
   // ----------------------------------------------------------------
   // Oscillator pins are foreign to clk, so synchronise first
   ago_sync #(
      .W (2)
   ) u_osc_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({slow_internal_oscillator, fast_internal_oscillator}),
      .sync_out (osc_sync)
   );

   ago_osc_counter u_osc_counter (
      .clk                   (clk),
      .rst_n                 (rst_n),
      .fast_sync             (osc_sync[0]),
      .slow_sync             (osc_sync[1]),
      .cycle_counter_control (cycle_counter_control),
      .osc_cycle_tally       (osc_cycle_tally)
   );

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // Gain register; bits 13:11 have no storage at all
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gain_sel_r  <= ago_pkg::GAIN_SEL_RST;
         gain_word_r <= ago_pkg::GAIN_WORD_RST;
      end else if (reg_wr && reg_addr == ago_pkg::GAIN_CORR_OFFS) begin
         gain_sel_r  <= reg_wdata[ago_pkg::GAIN_SEL_LSB +: 2]; // [R4]
         gain_word_r <= reg_wdata[ago_pkg::GAIN_WORD_LSB +: 11]; // [R12]
      end
   end

   // Offset register, all fields writable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         offs_sel_r           <= ago_pkg::OFFS_SEL_RST;
         first_offset_word_r  <= ago_pkg::OFFS_WORD_RST;
         second_offset_word_r <= ago_pkg::OFFS_WORD_RST;
      end else if (reg_wr && reg_addr == ago_pkg::OFFS_CORR_OFFS) begin
         offs_sel_r           <= reg_wdata[ago_pkg::OFFS_SEL_LSB +: 2];
         first_offset_word_r  <= reg_wdata[ago_pkg::OFFS1_LSB +: 7]; // [R10]
         second_offset_word_r <= reg_wdata[ago_pkg::OFFS2_LSB +: 7]; // [R10]
      end
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   // Register images as software sees them
   assign gain_reg_view = {gain_sel_r, 3'b000, gain_word_r}; // [R12]
   assign offs_reg_view = {offs_sel_r, first_offset_word_r,
                           second_offset_word_r};

   // Read decode; the monitor offset is read-only, unmapped reads zero
   always_comb begin
      rdata_nxt = ago_pkg::RDATA_RST;
      unique case (reg_addr)
         ago_pkg::OSCILLATOR_CYCLE_MONITOR_OFFS: rdata_nxt = osc_cycle_tally; // [R1]
         ago_pkg::GAIN_CORR_OFFS:   rdata_nxt = gain_reg_view;
         ago_pkg::OFFS_CORR_OFFS:   rdata_nxt = offs_reg_view;
         default:                   rdata_nxt = ago_pkg::RDATA_RST;
      endcase
   end

   // Read data registered; held until the next read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata  <= ago_pkg::RDATA_RST;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rdata_nxt;
         end
      end
   end

   // ----------------------------------------------------------------
   // Offset steering
   // ----------------------------------------------------------------
   // Axis each offset word lands on, from the angle axis pair
   always_comb begin
      off1_axis = ago_pkg::AXIS_NONE;
      off2_axis = ago_pkg::AXIS_NONE;
      unique case (angle_pair_code)
         ago_pkg::PAIR_NONE: begin
            off1_axis = ago_pkg::AXIS_NONE; // [R9]
            off2_axis = ago_pkg::AXIS_NONE; // [R9]
         end
         ago_pkg::PAIR_01: begin
            off1_axis = ago_pkg::AXIS_X; // [R7]
            off2_axis = ago_pkg::AXIS_Y; // [R8]
         end
         ago_pkg::PAIR_10: begin
            off1_axis = ago_pkg::AXIS_Y; // [R7]
            off2_axis = ago_pkg::AXIS_Z; // [R8]
         end
         ago_pkg::PAIR_11: begin
            off1_axis = ago_pkg::AXIS_X; // [R7]
            off2_axis = ago_pkg::AXIS_Z; // [R8]
         end
      endcase
   end

   assign axis_in[0] = axis_x;
   assign axis_in[1] = axis_y;
   assign axis_in[2] = axis_z;

   // ----------------------------------------------------------------
   // Per-axis correction
   // ----------------------------------------------------------------
   // Gain first, then offset, then saturate to 16 bits
   for (genvar a = 0; a < 3; a++) begin : g_axis
      logic [1:0]         my_code;
      logic               gain_hit;
      logic               off1_hit;
      logic               off2_hit;
      logic signed [27:0] prod;
      logic signed [17:0] scaled;
      logic signed [18:0] off1_ext;
      logic signed [18:0] off2_ext;
      logic signed [18:0] sum;
      logic [15:0]        sat;
      logic [15:0]        res_r;

      assign my_code  = 2'(a + 1);
      assign gain_hit = (gain_sel_r == my_code); // [R4]
      // Selector bit 0 enables word one, bit 1 word two; 00 none
      assign off1_hit = offs_sel_r[0] && (off1_axis == my_code); // [R6] [R7]
      assign off2_hit = offs_sel_r[1] && (off2_axis == my_code); // [R6] [R8]

      // Unsigned 11-bit gain, binary point ten places up
      assign prod   = $signed(axis_in[a]) * $signed({1'b0, gain_word_r});
      assign scaled = gain_hit ? 18'(prod >>> ago_pkg::GAIN_FRAC_BITS)
                               : 18'($signed(axis_in[a])); // [R5]

      // Offset LSB weighs one step of the 11-bit scale
      assign off1_ext = 19'($signed(first_offset_word_r))
                        <<< ago_pkg::OFFS_SHIFT; // [R11]
      assign off2_ext = 19'($signed(second_offset_word_r))
                        <<< ago_pkg::OFFS_SHIFT; // [R11]

      assign sum = 19'(scaled)
                 + (off1_hit ? off1_ext : 19'sh0_0000) // [R9]
                 + (off2_hit ? off2_ext : 19'sh0_0000); // [R9]

      // Clamp rather than wrap: a wrapped sample flips the angle
      always_comb begin
         if (sum > 19'sh0_7fff) begin
            sat = 16'h7fff;
         end else if (sum < -19'sh0_8000) begin
            sat = 16'h8000;
         end else begin
            sat = sum[15:0];
         end
      end

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            res_r <= 16'h0000;
         end else if (axis_valid) begin
            res_r <= sat;
         end
      end
   end

   // ----------------------------------------------------------------
   // Corrected outputs
   // ----------------------------------------------------------------
   // One cycle of latency from sample to corrected sample
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         corr_valid <= 1'b0;
      end else begin
         corr_valid <= axis_valid;
      end
   end

   assign corr_x = g_axis[0].res_r;
   assign corr_y = g_axis[1].res_r;
   assign corr_z = g_axis[2].res_r;

endmodule

// ---- test/ago_regs_monitor.sv ----
`timescale 1ns/1ps
module ago_regs_monitor (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic [1:0]  cycle_counter_control,
   input wire logic        axis_valid,
   input wire logic        corr_valid,
   input wire logic [15:0] corr_x,
   input wire logic [15:0] corr_y,
   input wire logic [15:0] corr_z
);
   // ------------------------------------------------
   // Port timing and read values
   // ------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_rd_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read answer missing");
   chk_rd_pulse: assert property (!reg_rd |=> !reg_rvalid)
      else $error("read valid without read");
   chk_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without read");
   chk_resv_zero: assert property (reg_rd && reg_addr == 8'h11
      |=> reg_rdata[13:11] == 3'h0)
      else $error("reserved gain bits not zero");
   chk_unmapped_zero: assert property (reg_rd && reg_addr > 8'h12
      |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   // Two cycles of clear guarantee an in-flight count has landed
   chk_tally_clear: assert property (
      (cycle_counter_control == 2'h0)[*2] ##0
      (reg_rd && reg_addr == 8'h10) |=> reg_rdata == 16'h0000)
      else $error("tally not cleared");
   chk_corr_answer: assert property (axis_valid |=> corr_valid)
      else $error("corrected sample missing");
   chk_corr_pulse: assert property (!axis_valid |=> !corr_valid)
      else $error("corrected valid without sample");
   chk_corr_hold: assert property (!axis_valid |=> $stable(corr_x)
      && $stable(corr_y) && $stable(corr_z))
      else $error("corrected sample moved");

   cover property (reg_wr && reg_addr == 8'h12);
   cover property (reg_rd && reg_addr == 8'h10);
   cover property (axis_valid ##1 corr_valid);
endmodule

bind ago_regs ago_regs_monitor mon (
   .clk                   (clk),
   .rst_n                 (rst_n),
   .reg_addr              (reg_addr),
   .reg_wr                (reg_wr),
   .reg_rd                (reg_rd),
   .reg_rdata             (reg_rdata),
   .reg_rvalid            (reg_rvalid),
   .cycle_counter_control (cycle_counter_control),
   .axis_valid            (axis_valid),
   .corr_valid            (corr_valid),
   .corr_x                (corr_x),
   .corr_y                (corr_y),
   .corr_z                (corr_z)
);

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   logic        clk, rst_n, reg_wr, reg_rd, reg_rvalid, axis_valid;
   logic        fast_internal_oscillator, slow_internal_oscillator;
   logic        corr_valid;
   logic [7:0]  reg_addr;
   logic [1:0]  cycle_counter_control, angle_pair_code;
   logic [15:0] reg_wdata, reg_rdata, axis_x, axis_y, axis_z;
   logic [15:0] corr_x, corr_y, corr_z;
   int          err_total, samples_checked, cycles, ox, oy, oz;

   ago_regs dut (
      .clk                      (clk),
      .rst_n                    (rst_n),
      .reg_addr                 (reg_addr),
      .reg_wdata                (reg_wdata),
      .reg_wr                   (reg_wr),
      .reg_rd                   (reg_rd),
      .reg_rdata                (reg_rdata),
      .reg_rvalid               (reg_rvalid),
      .cycle_counter_control    (cycle_counter_control),
      .fast_internal_oscillator (fast_internal_oscillator),
      .slow_internal_oscillator (slow_internal_oscillator),
      .angle_pair_code          (angle_pair_code),
      .axis_valid               (axis_valid),
      .axis_x                   (axis_x),
      .axis_y                   (axis_y),
      .axis_z                   (axis_z),
      .corr_valid               (corr_valid),
      .corr_x                   (corr_x),
      .corr_y                   (corr_y),
      .corr_z                   (corr_z)
   );

   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard, about twenty times the expected run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         final_report();
      end
   end

   // ------------------------------------------------
   // Tasks, entered and left at a falling edge
   // ------------------------------------------------
   task automatic check(input string nm, input logic [15:0] seen, e);
      samples_checked++;
      if (seen !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, seen);
      end
   endtask

   // Idle cycle after each strobe keeps every pulse one cycle wide
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      @(negedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      check("reg_rvalid", {15'h0, reg_rvalid}, 16'h0001);
      check("reg_rdata", reg_rdata, e);
      @(negedge clk);
   endtask

   task automatic samp(input logic [15:0] x, y, z, ex, ey, ez);
      {axis_x, axis_y, axis_z} = {x, y, z};
      axis_valid = 1'b1;
      @(negedge clk);
      axis_valid = 1'b0;
      check("corr_valid", {15'h0, corr_valid}, 16'h0001);
      check("corr_x", corr_x, ex);
      check("corr_y", corr_y, ey);
      check("corr_z", corr_z, ez);
      @(negedge clk);
   endtask

   // Pins held 3 cycles per level, inside the counted speed range
   task automatic osc(input int n, input logic [1:0] pins);
      repeat (n) begin
         {fast_internal_oscillator, slow_internal_oscillator} = pins;
         repeat (3) @(negedge clk);
         {fast_internal_oscillator, slow_internal_oscillator} = 2'b00;
         repeat (3) @(negedge clk);
      end
      repeat (4) @(negedge clk);
   endtask

   function automatic logic [15:0] fix(input int v);
      if (v > 32767) return 16'h7FFF;
      if (v < -32768) return 16'h8000;
      return v[15:0];
   endfunction

   task automatic final_report();
      if (err_total == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ------------------------------------------------
   // Main sequence
   // ------------------------------------------------
   initial begin
      {rst_n, reg_wr, reg_rd, axis_valid, reg_addr, reg_wdata} = '0;
      {cycle_counter_control, angle_pair_code} = '0;
      {fast_internal_oscillator, slow_internal_oscillator} = 2'b00;
      {axis_x, axis_y, axis_z} = '0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      for (int a = 16; a < 19; a++) rd(a[7:0], 16'h0000);
      wr(8'h11, 16'hFFFF);
      rd(8'h11, 16'hC7FF);
      wr(8'h13, 16'hFFFF);
      rd(8'h13, 16'h0000);
      for (int s = 0; s < 4; s++) begin
         wr(8'h11, {s[1:0], 3'h0, 11'h200});
         samp(16'h1000, 16'hF000, 16'h0400,
            s == 1 ? 16'h0800 : 16'h1000,
            s == 2 ? 16'hF800 : 16'hF000,
            s == 3 ? 16'h0200 : 16'h0400);
      end
      wr(8'h11, 16'h47FF);
      samp(16'h1000, 16'h0, 16'h0, 16'h1FFC, 16'h0, 16'h0);
      wr(8'h11, 16'h0000);
      for (int s = 0; s < 4; s++)
         for (int p = 0; p < 4; p++) begin
            angle_pair_code = p[1:0];
            wr(8'h12, {s[1:0], 7'h40, 7'h3F});
            ox = (s[0] && p[0]) ? -2048 : 0;
            oy = (s[0] && p == 2 ? -2048 : 0) + (s[1] && p == 1 ? 2016 : 0);
            oz = (s[1] && p[1]) ? 2016 : 0;
            samp(16'h8100, 16'h0100, 16'h7F00, fix(ox - 32512),
               fix(256 + oy),
               fix(32512 + oz));
         end
      rd(8'h12, 16'hE03F);
      // Pulses on the unselected source must not be counted
      cycle_counter_control = 2'h1;
      osc(5, 2'b10);
      osc(2, 2'b01);
      cycle_counter_control = 2'h3;
      osc(4, 2'b11);
      rd(8'h10, 16'h0005);
      cycle_counter_control = 2'h0;
      @(negedge clk);
      rd(8'h10, 16'h0000);
      cycle_counter_control = 2'h2;
      osc(3, 2'b01);
      osc(2, 2'b10);
      cycle_counter_control = 2'h3;
      wr(8'h10, 16'h1234);
      rd(8'h10, 16'h0003);
      final_report();
   end
endmodule
